/* design/strobe_width_address_translator.sv */
`timescale 1ns/1ns
// Function
// [R1] 8-bit size keeps only the low byte
// [R2] Byte to 16-bit memory: address bit zero picks lane
// [R3] 16-bit memory address starts at pin A-1
// [R4] 32-bit memory: no shift, A0 is word bit
// [R5] Translation and packing follow space size and width
// [R6] Shared mode ANDs both groups onto primary lines
// [R7] Shared mode only when shared select bit set
// [R8] Logical address range picks the governing space
// [R9] Each space sets its own lanes and cycles
// [R10] 16-bit data to 32-bit memory: shift one
// [R11] 8-bit data to 32-bit memory: shift two
// [R12] Odd halfword on 32-bit memory: upper lanes only
// [R13] 32-bit access to 32-bit memory: all lanes once
// [R14] Insert programmed wait states in every bus cycle
// [R15] Narrow memory turns upper strobes into low address
// [R16] Size over width splits into consecutive cycles
// [R17] Unselected byte strobes stay released all cycle
module strobe_width_address_translator (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Access request from the core, same clock domain.
    input wire logic req_valid_in,
    input wire strobe_xlate_pkg::access_req_t req_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [strobe_xlate_pkg::DATA_W-1:0] rdata_out,
    // Strobe space settings.
    input wire logic shared_strobe_select_in,
    input wire strobe_xlate_pkg::space_cfg_t primary_cfg_in,
    input wire strobe_xlate_pkg::space_cfg_t secondary_cfg_in,
    // External memory pins.
    output logic [strobe_xlate_pkg::ADDR_W-1:0] addr_out,
    output logic [strobe_xlate_pkg::LANES-1:0] primary_strobe_group_n_out,
    output logic [strobe_xlate_pkg::LANES-1:0] secondary_strobe_group_n_out,
    output logic write_n_out,
    output logic [strobe_xlate_pkg::DATA_W-1:0] data_out,
    output logic data_oe_out,
    input wire logic [strobe_xlate_pkg::DATA_W-1:0] data_in
);

    // ========================================================
    // Helpers
    // ========================================================

    // Turns a size or width field into a byte exponent; the
    // unused code is treated as a full word.
    function automatic logic [1:0] size_exp(input logic [1:0] f);
        logic [1:0] e;
        e = strobe_xlate_pkg::EXP_32;
        if (f == strobe_xlate_pkg::SIZE_8) begin
            e = strobe_xlate_pkg::EXP_8;
        end else if (f == strobe_xlate_pkg::SIZE_16) begin
            e = strobe_xlate_pkg::EXP_16;
        end
        return e;
    endfunction

    // ========================================================
    // State
    // ========================================================

    strobe_xlate_pkg::xlate_state_t state, next_state;
    // Latched logical address, direction and truncated data.
    logic [strobe_xlate_pkg::ADDR_W-1:0] laddr, next_laddr;
    logic wr, next_wr;
    logic [strobe_xlate_pkg::DATA_W-1:0] wbuf, next_wbuf;
    // Settings of the space that owns the current access.
    strobe_xlate_pkg::space_cfg_t cfg, next_cfg;
    logic secondary, next_secondary;
    logic shared, next_shared;
    // Beat index, wait counter and settle counter.
    logic [1:0] beat, next_beat;
    logic [strobe_xlate_pkg::WAIT_W-1:0] wcnt, next_wcnt;
    logic [1:0] scnt, next_scnt;
    // Read data being gathered from the beats.
    logic [strobe_xlate_pkg::DATA_W-1:0] acc, next_acc;
    // Registered outputs.
    logic next_ready, next_done;
    logic [strobe_xlate_pkg::DATA_W-1:0] next_rdata;
    logic [strobe_xlate_pkg::ADDR_W-1:0] next_addr;
    logic [3:0] next_prim_n, next_sec_n;
    logic next_write_n, next_oe;
    logic [strobe_xlate_pkg::DATA_W-1:0] next_data;
    // Read data synchroniser; the first stage feeds only the second.
    logic [strobe_xlate_pkg::DATA_W-1:0] data_meta, data_sync;

    // ========================================================
    // Beat decode
    // ========================================================

    // Exponents, beat count and physical placement of a beat.
    logic [1:0] sexp, wexp, bexp, lane_off, last_beat;
    logic [strobe_xlate_pkg::PHYS_W-1:0] baddr;
    logic [3:0] lanes, space_n;
    logic [4:0] src_sh, dst_sh;
    logic [strobe_xlate_pkg::DATA_W-1:0] bmask, piece;

    // Works out address pins, strobes and data lanes of the
    // current beat from the latched access.
    always_comb begin
        sexp = size_exp(cfg.data_size); // [R5] [R9]
        wexp = size_exp(cfg.mem_width); // [R5] [R9]
        // A beat is never wider than the memory.
        bexp = (sexp < wexp) ? sexp : wexp;
        // Byte address: logical address scaled by the data size
        // plus the beat offset in memory-width units.
        baddr = strobe_xlate_pkg::PHYS_W'(
            {2'h0, laddr} << sexp) // [R10] [R11]
            + strobe_xlate_pkg::PHYS_W'(
            {{(strobe_xlate_pkg::PHYS_W-2){1'b0}}, beat}
            << wexp); // [R16]
        // Size over width needs 2^(sexp-wexp) beats.
        last_beat = (sexp > wexp)
            ? 2'((3'h1 << (sexp - wexp)) - 3'h1) : 2'h0; // [R16]
        // Byte lane within the memory word.
        lane_off = baddr[1:0] & 2'((3'h1 << wexp) - 3'h1);
        unique case (bexp)
            strobe_xlate_pkg::EXP_8: begin
                lanes = strobe_xlate_pkg::LANE_1;
                bmask = strobe_xlate_pkg::MASK_8;
            end
            strobe_xlate_pkg::EXP_16: begin
                lanes = strobe_xlate_pkg::LANE_2;
                bmask = strobe_xlate_pkg::MASK_16;
            end
            default: begin
                lanes = strobe_xlate_pkg::LANE_4; // [R13]
                bmask = strobe_xlate_pkg::MASK_32;
            end
        endcase
        // Odd halfword lands on the upper lanes, a byte on the lane
        // of its offset in the memory word; all others stay released.
        lanes = 4'(lanes << lane_off); // [R2] [R12] [R17]
        space_n = ~lanes;
        // Narrow memories borrow the upper strobes as address.
        if (wexp == strobe_xlate_pkg::EXP_16) begin
            space_n[3] = baddr[1]; // [R15] [R3]
            space_n[2] = 1'b1;
        end else if (wexp == strobe_xlate_pkg::EXP_8) begin
            space_n[3] = baddr[1]; // [R15]
            space_n[2] = baddr[0]; // [R15]
            space_n[1] = 1'b1;
        end
        // Shifts that move a beat between word and lane position.
        src_sh = 5'({beat, 3'h0} << wexp);
        dst_sh = {lane_off, 3'h0};
        piece = (data_sync >> dst_sh) & bmask;
    end

    // ========================================================
    // Controller
    // ========================================================

    // Accepts an access, runs each beat for one plus the wait
    // states, then lets the read data cross the synchroniser
    // before the next beat or the end of the access.
    always_comb begin
        next_state = state;
        next_laddr = laddr;
        next_wr = wr;
        next_wbuf = wbuf;
        next_cfg = cfg;
        next_secondary = secondary;
        next_shared = shared;
        next_beat = beat;
        next_wcnt = wcnt;
        next_scnt = scnt;
        next_acc = acc;
        next_done = 1'b0;
        next_rdata = rdata_out;
        unique case (state)
            strobe_xlate_pkg::ST_IDLE: begin
                if (req_valid_in) begin
                    next_laddr = req_in.addr;
                    next_wr = req_in.write;
                    // The address range picks the space.
                    next_secondary =
                        req_in.addr[strobe_xlate_pkg::SPACE_BIT]; // [R8]
                    next_cfg = next_secondary
                        ? secondary_cfg_in : primary_cfg_in; // [R9]
                    next_shared = shared_strobe_select_in; // [R7]
                    // Keep only the bits of the configured size.
                    unique case (size_exp(next_cfg.data_size))
                        strobe_xlate_pkg::EXP_8: begin
                            next_wbuf = req_in.wdata
                                & strobe_xlate_pkg::MASK_8; // [R1]
                        end
                        strobe_xlate_pkg::EXP_16: begin
                            next_wbuf = req_in.wdata
                                & strobe_xlate_pkg::MASK_16;
                        end
                        default: begin
                            next_wbuf = req_in.wdata;
                        end
                    endcase
                    next_beat = 2'h0;
                    next_wcnt = next_cfg.wait_states; // [R14]
                    next_acc = '0;
                    next_state = strobe_xlate_pkg::ST_STROBE;
                end
            end
            strobe_xlate_pkg::ST_STROBE: begin
                // Hold the strobe through the wait states.
                if (wcnt == '0) begin
                    next_scnt = 2'h0;
                    next_state = strobe_xlate_pkg::ST_SETTLE;
                end else begin
                    next_wcnt = wcnt - 1'b1; // [R14]
                end
            end
            strobe_xlate_pkg::ST_SETTLE: begin
                if (scnt == strobe_xlate_pkg::SYNC_CYC) begin
                    // Unpack this beat into its place in the word.
                    next_acc = acc | (piece << src_sh); // [R5]
                    if (beat == last_beat) begin
                        next_done = 1'b1;
                        next_rdata = next_acc;
                        next_state = strobe_xlate_pkg::ST_IDLE;
                    end else begin
                        next_beat = beat + 1'b1; // [R16]
                        next_wcnt = cfg.wait_states; // [R14]
                        next_state = strobe_xlate_pkg::ST_STROBE;
                    end
                end else begin
                    next_scnt = scnt + 1'b1;
                end
            end
            default: begin
                next_state = strobe_xlate_pkg::ST_IDLE;
            end
        endcase
        next_ready = (next_state == strobe_xlate_pkg::ST_IDLE);
    end

    // ========================================================
    // Pin drive
    // ========================================================

    // Pins follow the controller one cycle later, so the strobe
    // window also covers the first settle cycle and the write
    // data is still held there after the strobe edge.
    always_comb begin
        next_addr = baddr[strobe_xlate_pkg::PHYS_W-1:2]; // [R3] [R4]
        next_prim_n = strobe_xlate_pkg::STROBE_IDLE;
        next_sec_n = strobe_xlate_pkg::STROBE_IDLE;
        if (state == strobe_xlate_pkg::ST_STROBE) begin
            if (secondary) begin
                next_sec_n = space_n;
            end else begin
                next_prim_n = space_n;
            end
        end
        // Shared mode: both groups merge onto the primary lines,
        // the idle group contributing all ones.
        if (shared) begin
            next_prim_n = next_prim_n & next_sec_n; // [R6] [R7]
            next_sec_n = strobe_xlate_pkg::STROBE_IDLE;
        end
        next_write_n = !(wr && state != strobe_xlate_pkg::ST_IDLE);
        next_oe = wr && state != strobe_xlate_pkg::ST_IDLE;
        // Pack the beat's bytes onto the selected lanes.
        next_data = (wbuf >> src_sh) << dst_sh; // [R5]
    end

    // ========================================================
    // Registers
    // ========================================================

    // Registers every state value and every output.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= strobe_xlate_pkg::ST_IDLE;
            laddr <= '0;
            wr <= 1'b0;
            wbuf <= '0;
            cfg <= '0;
            secondary <= 1'b0;
            shared <= 1'b0;
            beat <= 2'h0;
            wcnt <= '0;
            scnt <= 2'h0;
            acc <= '0;
            data_meta <= '0;
            data_sync <= '0;
            req_ready_out <= 1'b1;
            done_out <= 1'b0;
            rdata_out <= '0;
            addr_out <= '0;
            primary_strobe_group_n_out <= strobe_xlate_pkg::STROBE_IDLE;
            secondary_strobe_group_n_out <= strobe_xlate_pkg::STROBE_IDLE;
            write_n_out <= 1'b1;
            data_out <= '0;
            data_oe_out <= 1'b0;
        end else begin
            state <= next_state;
            laddr <= next_laddr;
            wr <= next_wr;
            wbuf <= next_wbuf;
            cfg <= next_cfg;
            secondary <= next_secondary;
            shared <= next_shared;
            beat <= next_beat;
            wcnt <= next_wcnt;
            scnt <= next_scnt;
            acc <= next_acc;
            data_meta <= data_in;
            data_sync <= data_meta;
            req_ready_out <= next_ready;
            done_out <= next_done;
            rdata_out <= next_rdata;
            addr_out <= next_addr;
            primary_strobe_group_n_out <= next_prim_n;
            secondary_strobe_group_n_out <= next_sec_n;
            write_n_out <= next_write_n;
            data_out <= next_data;
            data_oe_out <= next_oe;
        end
    end

endmodule

/* design/strobe_xlate_pkg.sv */
// ============================================================
// Shared constants and types for the strobe width translator.
// ============================================================
package strobe_xlate_pkg;

    // Logical address width and external data width.
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    // Byte-granular physical address, two bits below pin A0.
    localparam int PHYS_W = ADDR_W + 2;
    // Number of byte strobe lines in a strobe group.
    localparam int LANES = 4;
    // Width of the wait-state field of a strobe space.
    localparam int WAIT_W = 4;
    // Logical address bit that picks the secondary strobe space.
    localparam int SPACE_BIT = 20;
    // Cycles of the two-stage read data synchroniser.
    localparam logic [1:0] SYNC_CYC = 2'h2;
    // Byte width exponents (0 = byte, 1 = halfword, 2 = word).
    localparam logic [1:0] EXP_8 = 2'h0;
    localparam logic [1:0] EXP_16 = 2'h1;
    localparam logic [1:0] EXP_32 = 2'h2;
    // Byte lane patterns for a one, two and four byte beat.
    localparam logic [3:0] LANE_1 = 4'h1;
    localparam logic [3:0] LANE_2 = 4'h3;
    localparam logic [3:0] LANE_4 = 4'hF;
    // Data masks for a one, two and four byte value.
    localparam logic [31:0] MASK_8 = 32'h000000FF;
    localparam logic [31:0] MASK_16 = 32'h0000FFFF;
    localparam logic [31:0] MASK_32 = 32'hFFFFFFFF;
    // All strobes released (active low).
    localparam logic [3:0] STROBE_IDLE = 4'hF;

    // Encoding of the data size and memory width fields.
    typedef enum logic [1:0] {
        SIZE_8 = 2'b00,
        SIZE_16 = 2'b01,
        SIZE_32 = 2'b11
    } xfer_size_t;

    // Settings of one strobe space.
    typedef struct packed {
        xfer_size_t data_size;
        xfer_size_t mem_width;
        logic [WAIT_W-1:0] wait_states;
    } space_cfg_t;

    // One access as issued by the processor core.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [DATA_W-1:0] wdata;
    } access_req_t;

    // Controller states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STROBE = 2'b01,
        ST_SETTLE = 2'b10
    } xlate_state_t;

endpackage

/* testbench/sram_model.sv */
`timescale 1ns/1ns
// ==============================================
// Static memory on the far side, kept as bytes.
module sram_model (
    // Clock and width of the attached memory.
    input wire logic clk_in,
    input wire strobe_xlate_pkg::xfer_size_t width_in,
    // Memory pins.
    input wire logic [23:0] addr_in,
    input wire logic [3:0] strobe_n_in,
    input wire logic write_n_in,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out
);
    logic [7:0] mem [int];
    logic [31:0] last = 32'h0;
    // Narrow memory takes its low address from the upper strobes.
    function automatic int at(int i);
        case (width_in)
            strobe_xlate_pkg::SIZE_8: begin
                return int'({addr_in, strobe_n_in[3:2]});
            end
            strobe_xlate_pkg::SIZE_16: begin
                return int'({addr_in, strobe_n_in[3], i[0]});
            end
            default: begin
                return int'({addr_in, i[1:0]});
            end
        endcase
    endfunction
    // A lane is live when its chip select is low and the width has it.
    function automatic logic sel(int i);
        if (width_in == strobe_xlate_pkg::SIZE_8) begin
            return i == 0 && !strobe_n_in[0];
        end
        if (width_in == strobe_xlate_pkg::SIZE_16) begin
            return i < 2 && !strobe_n_in[i];
        end
        return !strobe_n_in[i];
    endfunction
    // Writes land on each edge a lane is selected.
    always @(posedge clk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (sel(i) && !write_n_in) mem[at(i)] = data_in[8*i+:8];
            if (sel(i)) last <= data_out;
        end
    end
    // Released lanes show the inverse of the last value, never a hold.
    always_comb begin
        data_out = ~last;
        for (int i = 0; i < 4; i++) begin
            if (sel(i) && write_n_in) data_out[8*i+:8] = mem[at(i)];
        end
    end
endmodule

/* testbench/strobe_xlate_assertions.sv */
`timescale 1ns/1ns
// ==============================================
// Port checker for the strobe width translator.
module strobe_xlate_assertions (
    // Clock, reset and request side.
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire strobe_xlate_pkg::access_req_t req_in,
    input wire logic req_ready_out,
    input wire logic done_out,
    // Settings and memory pins.
    input wire logic shared_strobe_select_in,
    input wire strobe_xlate_pkg::space_cfg_t primary_cfg_in,
    input wire logic [strobe_xlate_pkg::LANES-1:0]
        primary_strobe_group_n_out,
    input wire logic [strobe_xlate_pkg::LANES-1:0]
        secondary_strobe_group_n_out,
    input wire logic write_n_out,
    input wire logic data_oe_out
);
    // Accept edge, the space bit and the shared bit held per access.
    logic take;
    logic hi;
    logic word0;
    logic shared_l;
    assign take = req_ready_out && req_valid_in;
    assign hi = req_in.addr[strobe_xlate_pkg::SPACE_BIT];
    // Word data, word memory, no wait states: the shortest access.
    assign word0 = take && !hi && primary_cfg_in == 8'hF0;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shared_l <= 1'b0;
        end else if (take) begin
            shared_l <= shared_strobe_select_in;
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Four busy cycles, then the one-cycle completion.
    sequence word_beat;
        !done_out [*4] ##1 done_out;
    endsequence
    done_pulse_a: assert property (done_out |=> !done_out)
        else $error("done held for more than one cycle");
    done_ready_a: assert property (done_out |-> req_ready_out)
        else $error("done without ready");
    busy_after_take_a: assert property (take |=> !req_ready_out [*2])
        else $error("ready while an access runs");
    word_time_a: assert property (word0 |-> ##1 word_beat)
        else $error("word access took the wrong time");
    word_lanes_a: assert property (word0 |->
        ##2 !primary_strobe_group_n_out)
        else $error("word access lost a lane");
    write_drive_a: assert property (take && req_in.write |-> ##2
        (!write_n_out && data_oe_out)) else $error("write not driven");
    read_release_a: assert property (take && !req_in.write |-> ##2
        (write_n_out && !data_oe_out)) else $error("read drives bus");
    space_pick_a: assert property (take && hi
        && !shared_strobe_select_in
        |-> ##2 secondary_strobe_group_n_out != 4'hF)
        else $error("secondary space not selected");
    shared_merge_a: assert property (take && hi
        && shared_strobe_select_in
        |-> ##2 primary_strobe_group_n_out != 4'hF)
        else $error("shared access missing on primary lines");
    shared_quiet_a: assert property (shared_l
        |-> secondary_strobe_group_n_out == 4'hF)
        else $error("secondary lines active in shared mode");
endmodule

bind strobe_width_address_translator strobe_xlate_assertions u_chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in),
    .req_in(req_in),
    .req_ready_out(req_ready_out),
    .done_out(done_out),
    .shared_strobe_select_in(shared_strobe_select_in),
    .primary_cfg_in(primary_cfg_in),
    .primary_strobe_group_n_out(primary_strobe_group_n_out),
    .secondary_strobe_group_n_out(secondary_strobe_group_n_out),
    .write_n_out(write_n_out),
    .data_oe_out(data_oe_out)
);

/* testbench/tb.sv */
`timescale 1ns/1ns
// ==============================================
// Self-checking bench for the strobe translator.
module tb;
    localparam strobe_xlate_pkg::xfer_size_t B8 = strobe_xlate_pkg::SIZE_8;
    localparam strobe_xlate_pkg::xfer_size_t B16 = strobe_xlate_pkg::SIZE_16;
    localparam strobe_xlate_pkg::xfer_size_t B32 = strobe_xlate_pkg::SIZE_32;
    localparam logic [31:0] WD = 32'hA1B2C3D4;
    // Row: size, width, waits, shared, address, first beat pins, beats.
    typedef struct {
        strobe_xlate_pkg::xfer_size_t sz;
        strobe_xlate_pkg::xfer_size_t wd;
        logic [3:0] ws;
        logic sh;
        logic [23:0] a;
        logic [23:0] ea;
        logic [3:0] es;
        int nb;
    } row_t;
    row_t rows [10];
    logic clk_in, rst_n_in, req_valid_in, shared_strobe_select_in;
    strobe_xlate_pkg::access_req_t req_in;
    strobe_xlate_pkg::space_cfg_t primary_cfg_in, secondary_cfg_in;
    strobe_xlate_pkg::xfer_size_t width;
    logic req_ready_out, done_out, write_n_out, data_oe_out;
    logic [31:0] rdata_out, data_out, mem_data;
    logic [23:0] addr_out;
    logic [3:0] pg, sg;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    strobe_width_address_translator uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .req_valid_in(req_valid_in), .req_in(req_in),
        .req_ready_out(req_ready_out), .done_out(done_out),
        .rdata_out(rdata_out),
        .shared_strobe_select_in(shared_strobe_select_in),
        .primary_cfg_in(primary_cfg_in),
        .secondary_cfg_in(secondary_cfg_in), .addr_out(addr_out),
        .primary_strobe_group_n_out(pg),
        .secondary_strobe_group_n_out(sg), .write_n_out(write_n_out),
        .data_out(data_out), .data_oe_out(data_oe_out), .data_in(mem_data)
    );
    // One memory serves both groups; an idle group stays all ones.
    sram_model mem (
        .clk_in(clk_in), .width_in(width), .addr_in(addr_out),
        .strobe_n_in(pg & sg), .write_n_in(write_n_out),
        .data_in(data_out), .data_out(mem_data)
    );
    always #5 clk_in = ~clk_in;
    // A hang is cut short well beyond the expected run length.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h", $time, msg, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Pins while reset is held: idle, released and cleared.
    task automatic idle_chk();
        chk({req_ready_out, done_out, write_n_out, data_oe_out, pg, sg},
            32'h00000AFF, "idle pins");
        chk(rdata_out | data_out | addr_out, 32'h0, "cleared values");
    endtask
    // One access of a row; the first active beat is captured.
    task automatic acc(input int i, input logic w);
        row_t r;
        logic [3:0] g;
        logic act;
        logic prev = 1'b0;
        int n = 0;
        int nb = 0;
        logic [23:0] fa = 24'h0;
        logic [3:0] fs = 4'hF;
        r = rows[i];
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_in <= {r.a, w, WD};
        shared_strobe_select_in <= r.sh;
        primary_cfg_in <= r.a[20] ? 8'hF0 : {r.sz, r.wd, r.ws};
        secondary_cfg_in <= {r.sz, r.wd, r.ws};
        width <= r.wd;
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        do begin
            @(posedge clk_in);
            n++;
            @(negedge clk_in);
            g = (r.a[20] && !r.sh) ? sg : pg;
            act = (r.wd == B32) ? (g != 4'hF) : (g[1:0] != 2'h3);
            if (act && !prev && nb++ == 0) begin
                fa = addr_out;
                fs = g;
            end
            prev = act;
        end while (done_out !== 1'b1 && n < 100);
        chk(n, r.nb * (r.ws + 4), "cycles to done");
        chk(nb, r.nb, "beats");
        chk(fa, r.ea, "address pins");
        chk(fs, r.es, "strobe pins");
        if (!w) chk(rdata_out, WD & (r.sz == B8 ? strobe_xlate_pkg::MASK_8 :
            r.sz == B16 ? strobe_xlate_pkg::MASK_16 :
            strobe_xlate_pkg::MASK_32), "read data");
    endtask
    initial begin
        clk_in = 1'b0;
        rst_n_in = 1'b0;
        req_valid_in = 1'b0;
        req_in = '0;
        shared_strobe_select_in = 1'b0;
        primary_cfg_in = '0;
        secondary_cfg_in = '0;
        width = B32;
        rows = '{'{B32, B32, 0, 0, 24'h000010, 24'h000010, 4'h0, 1},
            '{B16, B32, 0, 0, 24'h000003, 24'h000001, 4'h3, 1},
            '{B8, B32, 1, 0, 24'h000006, 24'h000001, 4'hB, 1},
            '{B8, B16, 0, 0, 24'h007FFF, 24'h001FFF, 4'hD, 1},
            '{B8, B16, 0, 0, 24'h000100, 24'h000040, 4'h6, 1},
            '{B32, B16, 0, 0, 24'h100000, 24'h100000, 4'h4, 2},
            '{B16, B8, 0, 0, 24'h100001, 24'h080000, 4'hA, 2},
            '{B8, B8, 2, 0, 24'h000007, 24'h000001, 4'hE, 1},
            '{B8, B32, 0, 1, 24'h100003, 24'h040000, 4'h7, 1},
            '{B32, B32, 0, 1, 24'h000020, 24'h000020, 4'h0, 1}};
        repeat (2) @(posedge clk_in);
        idle_chk();
        rst_n_in <= 1'b1;
        // Each row is written, then read back through the memory.
        for (int i = 0; i < 10; i++) begin
            acc(i, 1'b1);
            acc(i, 1'b0);
            $display("row %0d finished", i);
        end
        // Reset lands in the middle of an access; pins must drop at once.
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(negedge clk_in);
        idle_chk();
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        acc(0, 1'b1);
        acc(0, 1'b0);
        $display("abort test finished");
        print_verdict();
    end
endmodule
